// ---- uart_pkg.sv ----
`default_nettype none
package uart_pkg;
  // register byte offsets
  localparam logic [7:0] data_off = 8'h00;
  localparam logic [7:0] ctrl_off = 8'h04;
  localparam logic [7:0] ier_off = 8'h0c;
  localparam logic [7:0] stat_off = 8'h10;
  localparam logic [7:0] brd_off = 8'h24;
  localparam logic [7:0] test_off = 8'h28;
  // reset values
  localparam logic [31:0] ctrl_rst = 32'h0000_0000;
  localparam logic [31:0] stat_rst = 32'h0000_0180;
  localparam logic [15:0] brd_rst = 16'h0010;
  // line control fields
  localparam int ctrl_order_bit = 2;
  localparam int ctrl_txen_bit = 4;
  localparam int ctrl_rxen_bit = 5;
  localparam int ctrl_wls_lo = 8;
  localparam int ctrl_nsb_bit = 10;
  localparam int ctrl_pbe_bit = 11;
  localparam int ctrl_epe_bit = 12;
  localparam int ctrl_spe_bit = 13;
  localparam int ctrl_bcb_bit = 14;
  // status fields
  localparam int st_rxdne = 0;
  localparam int st_oei = 1;
  localparam int st_pei = 2;
  localparam int st_fei = 3;
  localparam int st_bii = 4;
  localparam int st_txde = 7;
  localparam int st_txc = 8;
  // interrupt enable fields
  localparam int ie_rxdr = 0;
  localparam int ie_rls = 1;
  localparam int ie_txde = 2;
  localparam int ie_txc = 3;
  // char length encodings and loopback modes
  localparam logic [1:0] wls_7 = 2'h0;
  localparam logic [1:0] wls_8 = 2'h1;
  localparam logic [1:0] lbm_echo = 2'h2;
  localparam logic [1:0] lbm_loop = 2'h3;
  localparam int frame_w = 13;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bus_req_type;

  typedef enum logic [2:0] {
    rx_idle, rx_start, rx_data, rx_par, rx_stop
  } rx_state_type;
endpackage : uart_pkg
`default_nettype wire

// ---- async_serial_uart.sv ----
// The strobed register port was decided locally.
`timescale 1ns/10ps
`default_nettype none
module async_serial_uart (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire uart_pkg::bus_req_type i_bus,
  output logic [31:0] o_rdata,
  input wire logic i_rxd,
  output logic o_txd,
  output logic o_irq
);
  import uart_pkg::*;

  logic [31:0] ctrl_q;
  logic [3:0] ier_q;
  logic [15:0] brd_q;
  logic [1:0] lbm_q;
  logic [8:0] tx_hold_q;
  logic tx_full_q;
  logic [frame_w-1:0] tx_frame_q;
  logic [3:0] tx_left_q;
  logic [15:0] tx_cnt_q;
  logic rx_meta_q, rx_sync_q, rx_prev_q;
  rx_state_type rx_state_q;
  logic [15:0] rx_cnt_q;
  logic [3:0] rx_idx_q;
  logic [8:0] rx_sh_q;
  logic rx_par_q;
  logic [8:0] rx_hold_q;
  logic rxdne_q, oei_q, pei_q, fei_q, bii_q;
  logic [3:0] nbits;
  logic msb_first, pbe, nsb;
  logic wr_data, wr_stat, rd_data;
  logic tx_busy, tx_load, tx_tick, tx_bit;
  logic rx_line, rx_fall, rx_tick, rx_done;
  logic [8:0] rx_char;
  logic rx_pe, rx_fe, rx_brk;
  logic [31:0] stat_word;
  always_comb begin
    case (ctrl_q[ctrl_wls_lo +: 2])
      wls_7: nbits = 4'h7;
      wls_8: nbits = 4'h8;
      default: nbits = 4'h9;
    endcase
  end
  assign msb_first = ctrl_q[ctrl_order_bit];
  assign pbe = ctrl_q[ctrl_pbe_bit];
  assign nsb = ctrl_q[ctrl_nsb_bit];

  function automatic logic [8:0] mask_char(input logic [8:0] d,
                                           input logic [3:0] n);
    logic [8:0] m;
    m = 9'h1ff >> (4'h9 - n);
    return d & m;
  endfunction : mask_char
  // parity over the masked character; stick mode forces a constant
  function automatic logic par_of(input logic [8:0] d,
                                 input logic [31:0] c);
    logic p;
    p = ^d;
    if (c[ctrl_spe_bit]) begin
      p = ~c[ctrl_epe_bit];
    end else if (!c[ctrl_epe_bit]) begin
      p = ~p;
    end
    return p;
  endfunction : par_of
  // frame shifts out from bit 0; spare high bits stay 1 as idle
  function automatic logic [frame_w-1:0] build(input logic [8:0] d,
      input logic [3:0] n, input logic msb, input logic pe,
      input logic [31:0] c);
    logic [frame_w-1:0] f;
    logic [3:0] src;
    f = '1;
    f[0] = 1'b0;
    for (int i = 0; i < 9; i++) begin
      src = msb ? 4'(int'(n) - 1 - i) : 4'(i);
      if (4'(i) < n) begin
        f[i + 1] = d[src];
      end
    end
    if (pe) begin
      f[n + 4'h1] = par_of(d, c);
    end
    return f;
  endfunction : build

  // register port decode
  assign wr_data = i_bus.wr && (i_bus.addr == data_off);
  assign wr_stat = i_bus.wr && (i_bus.addr == stat_off);
  assign rd_data = i_bus.rd && (i_bus.addr == data_off);

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl_q <= ctrl_rst;
      ier_q <= '0;
      brd_q <= brd_rst;
      lbm_q <= '0;
    end else if (i_bus.wr) begin
      case (i_bus.addr)
        ctrl_off: ctrl_q <= i_bus.wdata;
        ier_off: ier_q <= i_bus.wdata[3:0];
        brd_off: brd_q <= i_bus.wdata[15:0];
        test_off: lbm_q <= i_bus.wdata[1:0];
        default: ;
      endcase
    end
  end

  // ---------------- transmitter
  assign tx_busy = tx_left_q != 4'h0;
  assign tx_load = tx_full_q && !tx_busy && ctrl_q[ctrl_txen_bit];
  assign tx_tick = tx_busy && (tx_cnt_q == brd_q - 16'h1);
  assign tx_bit = tx_busy ? tx_frame_q[0] : 1'b1;

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tx_hold_q <= '0;
      tx_full_q <= 1'b0;
    end else if (wr_data) begin
      tx_hold_q <= mask_char(i_bus.wdata[8:0], nbits);
      tx_full_q <= 1'b1;
    end else if (tx_load) begin
      tx_full_q <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tx_frame_q <= '1;
      tx_left_q <= '0;
      tx_cnt_q <= '0;
    end else if (tx_load) begin
      tx_frame_q <= build(tx_hold_q, nbits, msb_first, pbe, ctrl_q);
      tx_left_q <= 4'(nbits + 4'h2 + {3'h0, pbe} + {3'h0, nsb});
      tx_cnt_q <= '0;
    end else if (tx_tick) begin
      tx_frame_q <= {1'b1, tx_frame_q[frame_w-1:1]};
      tx_left_q <= tx_left_q - 4'h1;
      tx_cnt_q <= '0;
    end else if (tx_busy) begin
      tx_cnt_q <= tx_cnt_q + 16'h1;
    end
  end

  // break forces spacing; echo mode hands the received line back
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_txd <= 1'b1;
    end else if (ctrl_q[ctrl_bcb_bit]) begin
      o_txd <= 1'b0;
    end else if (lbm_q == lbm_echo) begin
      o_txd <= rx_sync_q;
    end else begin
      o_txd <= tx_bit;
    end
  end

  // ---------------- receiver
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rx_meta_q <= 1'b1;
      rx_sync_q <= 1'b1;
      rx_prev_q <= 1'b1;
    end else begin
      rx_meta_q <= i_rxd;
      rx_sync_q <= rx_meta_q;
      rx_prev_q <= rx_line;
    end
  end

  assign rx_line = (lbm_q == lbm_loop) ? tx_bit : rx_sync_q;
  assign rx_fall = rx_prev_q && !rx_line;
  assign rx_tick = (rx_state_q != rx_idle) && (rx_cnt_q == 16'h0);
  assign rx_done = (rx_state_q == rx_stop) && rx_tick;
  assign rx_char = mask_char(rx_sh_q, nbits);
  // parity result is settled before the stop bit is looked at
  assign rx_pe = pbe && (rx_par_q != par_of(rx_char, ctrl_q));
  assign rx_fe = !rx_line;
  assign rx_brk = rx_fe && (rx_char == 9'h0) && !(pbe && rx_par_q);

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rx_state_q <= rx_idle;
      rx_cnt_q <= '0;
      rx_idx_q <= '0;
      rx_sh_q <= '0;
      rx_par_q <= 1'b0;
    end else begin
      if (rx_state_q != rx_idle) begin
        rx_cnt_q <= rx_tick ? brd_q - 16'h1 : rx_cnt_q - 16'h1;
      end
      case (rx_state_q)
        rx_idle: begin
          if (rx_fall && ctrl_q[ctrl_rxen_bit]) begin
            // half a bit lands the samples mid-cell
            rx_cnt_q <= {1'b0, brd_q[15:1]} - 16'h1;
            rx_state_q <= rx_start;
          end
        end
        rx_start: begin
          if (rx_tick) begin
            rx_idx_q <= '0;
            rx_sh_q <= '0;
            // a glitch that is high by mid-cell is not a start
            rx_state_q <= rx_line ? rx_idle : rx_data;
          end
        end
        rx_data: begin
          if (rx_tick) begin
            if (msb_first) begin
              rx_sh_q[4'(nbits - 4'h1 - rx_idx_q)] <= rx_line;
            end else begin
              rx_sh_q[rx_idx_q] <= rx_line;
            end
            rx_idx_q <= rx_idx_q + 4'h1;
            if (rx_idx_q == nbits - 4'h1) begin
              rx_state_q <= pbe ? rx_par : rx_stop;
            end
          end
        end
        rx_par: begin
          if (rx_tick) begin
            rx_par_q <= rx_line;
            rx_state_q <= rx_stop;
          end
        end
        rx_stop: begin
          if (rx_tick) begin
            rx_state_q <= rx_idle;
          end
        end
        default: rx_state_q <= rx_idle;
      endcase
    end
  end

  // unread character is kept; the new one is lost on overrun
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rx_hold_q <= '0;
    end else if (rx_done && !rxdne_q) begin
      rx_hold_q <= rx_char;
    end
  end

  // sticky flags: a set in the same cycle as a clear wins
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rxdne_q <= stat_rst[st_rxdne];
      oei_q <= stat_rst[st_oei];
      pei_q <= stat_rst[st_pei];
      fei_q <= stat_rst[st_fei];
      bii_q <= stat_rst[st_bii];
    end else begin
      rxdne_q <= rx_done || (rxdne_q && !rd_data);
      oei_q <= (rx_done && rxdne_q) ||
               (oei_q && !(wr_stat && i_bus.wdata[st_oei]));
      pei_q <= (rx_done && rx_pe) ||
               (pei_q && !(wr_stat && i_bus.wdata[st_pei]));
      fei_q <= (rx_done && rx_fe) ||
               (fei_q && !(wr_stat && i_bus.wdata[st_fei]));
      bii_q <= (rx_done && rx_brk) ||
               (bii_q && !(wr_stat && i_bus.wdata[st_bii]));
    end
  end

  always_comb begin
    stat_word = '0;
    stat_word[st_rxdne] = rxdne_q;
    stat_word[st_oei] = oei_q;
    stat_word[st_pei] = pei_q;
    stat_word[st_fei] = fei_q;
    stat_word[st_bii] = bii_q;
    stat_word[st_txde] = !tx_full_q;
    stat_word[st_txc] = !tx_full_q && !tx_busy;
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rdata <= '0;
    end else if (i_bus.rd) begin
      case (i_bus.addr)
        data_off: o_rdata <= {23'h0, mask_char(rx_hold_q, nbits)};
        ctrl_off: o_rdata <= ctrl_q;
        ier_off: o_rdata <= {28'h0, ier_q};
        stat_off: o_rdata <= stat_word;
        brd_off: o_rdata <= {16'h0, brd_q};
        test_off: o_rdata <= {30'h0, lbm_q};
        default: o_rdata <= '0;
      endcase
    end else begin
      o_rdata <= '0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= (ier_q[ie_rxdr] && rxdne_q) ||
               (ier_q[ie_rls] && (oei_q || pei_q || fei_q || bii_q)) ||
               (ier_q[ie_txde] && stat_word[st_txde]) ||
               (ier_q[ie_txc] && stat_word[st_txc]);
    end
  end

  // ---------------- checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);

  a_txde_on_move: assert property (
    tx_load && !wr_data |=> stat_word[st_txde] && tx_busy)
    else $error("holding not emptied on move to shifter");
  a_start_low: assert property (
    tx_load |=> !tx_bit [*2])
    else $error("start bit not low after load");
  a_txc_end: assert property (
    tx_busy && tx_left_q == 4'h1 && tx_tick && !tx_full_q && !wr_data
      |=> stat_word[st_txc])
    else $error("transmit complete missing after last bit");
  a_baud_step: assert property (
    tx_tick && tx_left_q > 4'h1 && $stable(brd_q)
      |=> !tx_tick ##0 tx_cnt_q == 16'h0)
    else $error("bit period does not follow divisor");
  a_rx_ready: assert property (
    rx_done && !rxdne_q |=> rxdne_q && rx_hold_q == $past(rx_char))
    else $error("received character not made ready");
  a_overrun_keep: assert property (
    rx_done && rxdne_q && !rd_data |=> oei_q && $stable(rx_hold_q))
    else $error("overrun not flagged or data overwritten");
  a_framing_err: assert property (
    rx_done && !rx_line |=> fei_q && rxdne_q)
    else $error("framing error not flagged");
  a_irq_gated: assert property (
    ier_q == 4'h0 && $past(ier_q) == 4'h0 |-> !o_irq)
    else $error("interrupt without enable");
  a_bit8_zero: assert property (
    rd_data && nbits != 4'h9 |=> o_rdata[8] == 1'b0)
    else $error("bit 8 not zero outside nine-bit mode");

  c_tx_frame: cover property (tx_load ##[1:1000] !tx_busy);
  c_rx_char: cover property (rx_done && !rx_fe && !rx_pe);
  c_rx_parity_err: cover property (rx_done && rx_pe);
  c_overrun: cover property (rx_done && rxdne_q);
endmodule : async_serial_uart
`default_nettype wire

// ---- remote_serial.sv ----
`timescale 1ns/10ps
`default_nettype none
module remote_serial (
  input wire logic i_clk,
  input wire logic i_line,
  output logic o_line
);
  // idle high between frames, as a pulled-up line would rest
  initial o_line = 1'b1;

  // frame bits come start first; data order and parity set by caller
  task automatic send_frame(input logic [12:0] f, input int len,
                            input int bt);
    for (int k = 0; k < len; k++) begin
      o_line <= f[k];
      repeat (bt) @(posedge i_clk);
    end
    o_line <= 1'b1;
  endtask : send_frame

  // samples at bit centres from the falling start edge
  task automatic take_frame(output logic [12:0] f, input int len,
                            input int bt);
    f = '0;
    @(negedge i_line);
    repeat (bt / 2) @(posedge i_clk);
    for (int k = 0; k < len; k++) begin
      #1 f[k] = i_line;
      repeat (bt) @(posedge i_clk);
    end
  endtask : take_frame
endmodule : remote_serial
`default_nettype wire

// ---- async_serial_uart_test.sv ----
`timescale 1ns/10ps
`default_nettype none
module async_serial_uart_test;
  import uart_pkg::*;
  logic clk, rstn, rxd, txd, irq;
  bus_req_type bus;
  logic [31:0] rdata;
  int fail_count = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [7:0] ra [7] = '{data_off, ctrl_off, ier_off, stat_off, brd_off,
                          test_off, 8'h08};
  logic [31:0] rv [7] = '{32'h0, 32'h0, 32'h0, 32'h180, 32'h10, 32'h0,
                          32'h0};
  // length, order, parity and stop choices per pass
  logic [31:0] cfg [7] = '{32'h0000, 32'h1904, 32'h0e00, 32'h0500,
                           32'h1804, 32'h0604, 32'h2e04};

  async_serial_uart dut_u (
    .i_sys_clk(clk),
    .i_rstn(rstn),
    .i_bus(bus),
    .o_rdata(rdata),
    .i_rxd(rxd),
    .o_txd(txd),
    .o_irq(irq)
  );
  remote_serial far_u (.i_clk(clk), .i_line(txd), .o_line(rxd));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : give_verdict

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      fail_count++;
      give_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '0;
    #1 d = rdata;
  endtask : rd

  // expected line frame, bit 0 is the start bit
  function automatic logic [12:0] frame(input logic [31:0] d,
                                        input logic [31:0] c,
                                        output int len);
    int n;
    logic p;
    logic [12:0] f;
    n = c[9] ? 9 : (c[8] ? 8 : 7);
    f = '0;
    p = 1'b0;
    for (int k = 0; k < n; k++) begin
      f[1 + k] = c[2] ? d[n - 1 - k] : d[k];
      p ^= d[k];
    end
    len = 1 + n;
    if (c[11]) begin
      f[len] = c[13] ? ~c[12] : (c[12] ? p : ~p);
      len++;
    end
    f[len] = 1'b1;
    len++;
    if (c[10]) begin
      f[len] = 1'b1;
      len++;
    end
    return f;
  endfunction : frame

  initial begin
    logic [31:0] v, ctl, td, rdv, msk;
    logic [12:0] got, txf, rxf;
    int n, tl, rl, bt;
    logic pe, fe;
    logic [31:0] exp_q [$];
    rstn = 1'b0;
    bus = '0;
    void'($urandom(89));
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      rd(ra[i], v);
      chk(v, rv[i]);
    end
    wr(ier_off, 32'h2);
    for (int i = 0; i < 7; i++) begin
      ctl = cfg[i];
      bt = 16 + 3 * i;
      n = ctl[9] ? 9 : (ctl[8] ? 8 : 7);
      msk = (32'h1 << n) - 32'h1;
      td = $urandom;
      rdv = $urandom | 32'h1;
      pe = (i == 4);
      fe = (i == 5);
      wr(brd_off, bt);
      wr(ctrl_off, ctl | 32'h30);
      txf = frame(td, ctl, tl);
      rxf = frame(rdv, ctl, rl);
      if (pe) rxf[n + 1] = ~rxf[n + 1];
      if (fe) rxf[1 + n + int'(ctl[11])] = 1'b0;
      exp_q.push_back(rdv & msk);
      fork
        wr(data_off, td);
        far_u.take_frame(got, tl, bt);
        far_u.send_frame(rxf, rl, bt);
      join
      chk(got, txf);
      repeat (bt) @(posedge clk);
      rd(stat_off, v);
      chk(v & 32'h1ff, 32'h181 | {28'h0, fe, pe, 2'h0});
      chk(irq, pe | fe);
      rd(data_off, v);
      chk(v, exp_q.pop_front());
      wr(stat_off, 32'h1e);
      repeat (2) @(posedge clk);
      #1 chk(irq, 1'b0);
    end
    // a second character lands while the first is still unread
    rxf = frame(rdv, ctl, rl);
    txf = frame(~rdv, ctl, rl);
    exp_q.push_back(rdv & msk);
    far_u.send_frame(rxf, rl, bt);
    @(posedge clk);
    far_u.send_frame(txf, rl, bt);
    repeat (2) @(posedge clk);
    rd(stat_off, v);
    chk(v & 32'h3, 32'h3);
    chk(irq, 1'b1);
    rd(data_off, v);
    chk(v, exp_q.pop_front());
    wr(ier_off, 32'h8);
    repeat (2) @(posedge clk);
    #1 chk(irq, 1'b1);
    // all-zero character with a low stop bit reads as a break
    wr(stat_off, 32'h1e);
    wr(ier_off, 32'h1);
    repeat (2) @(posedge clk);
    #1 chk(irq, 1'b0);
    far_u.send_frame(13'h0, rl, bt);
    repeat (2) @(posedge clk);
    rd(stat_off, v);
    chk(v & 32'h1ff, 32'h19d);
    chk(irq, 1'b1);
    rd(data_off, v);
    chk(v, 32'h0);
    // internal loopback hands the transmitter to the receiver
    wr(stat_off, 32'h1e);
    wr(test_off, 32'h3);
    td = $urandom;
    txf = frame(td, ctl, tl);
    fork
      wr(data_off, td);
      far_u.take_frame(got, tl, bt);
    join
    chk(got, txf);
    rd(stat_off, v);
    chk(v & 32'h1ff, 32'h181);
    rd(data_off, v);
    chk(v, td & msk);
    // echo sends the received line straight back out
    wr(test_off, 32'h2);
    rxf = frame(rdv, ctl, rl);
    fork
      far_u.send_frame(rxf, rl, bt);
      far_u.take_frame(got, rl, bt);
    join
    chk(got, rxf);
    rd(data_off, v);
    chk(v, rdv & msk);
    // break holds the output at the spacing level
    wr(test_off, 32'h0);
    wr(ctrl_off, ctl | 32'h4030);
    repeat (2) @(posedge clk);
    #1 chk(txd, 1'b0);
    wr(ctrl_off, ctl | 32'h30);
    repeat (2) @(posedge clk);
    #1 chk(txd, 1'b1);
    // holding-empty event drops while the holding register is full
    wr(ier_off, 32'h4);
    wr(ctrl_off, ctl);
    wr(data_off, td);
    repeat (2) @(posedge clk);
    #1 chk(irq, 1'b0);
    wr(ctrl_off, ctl | 32'h30);
    repeat (2) @(posedge clk);
    #1 chk(irq, 1'b1);
    give_verdict();
  end
endmodule : async_serial_uart_test
`default_nettype wire
